// >>> logic/bors_pkg.sv
// Package: constants and carrier types for the brown-out reset sequencer
package bors_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS = 100;
  // Power-up delay in ms, and its count in clock cycles
  localparam int unsigned PWRUP_DELAY_MS = 96;
  localparam int unsigned PWRUP_CYCLES = PWRUP_DELAY_MS * (CLK_HZ / 1000);
  // Oscillator start-up delay in oscillator periods
  localparam int unsigned OSC_STARTUP_PERIODS = 1024;
  // Minimum low-supply time before reset is taken, in ns
  localparam int unsigned DIP_MIN_NS = 1000;
  localparam int unsigned DIP_CYCLES =
    (DIP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned DIP_W = 8;

  // ----------------------------------------------------------------
  // Interrupt vector and cause layout
  // ----------------------------------------------------------------
  localparam logic [15:0] IRQ_VECTOR = 16'h0020;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam int unsigned CAUSE_W = 8;
  localparam logic [CAUSE_W-1:0] CAUSE_RST = 8'h00;

  // ----------------------------------------------------------------
  // Reset kinds and states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    BORS_RK_NONE,
    BORS_RK_POWERON,
    BORS_RK_LOWSUP,
    BORS_RK_MASTER_CLEAR_INPUT,
    BORS_RK_WDT,
    BORS_RK_WAKE
  } bors_reset_kind_t;

  typedef enum {
    BORS_ST_HOLD,
    BORS_ST_DELAY,
    BORS_ST_RUN
  } bors_state_t;

  // Wake event as seen by the core
  typedef struct packed {
    logic valid;
    logic [CAUSE_W-1:0] core_cause;
    logic [CAUSE_W-1:0] periph_a_cause;
    logic [CAUSE_W-1:0] periph_b_cause;
  } bors_wake_t;

  // Program counter load directive
  typedef struct packed {
    logic load;
    logic push;
    logic [15:0] addr;
  } bors_pc_t;

endpackage

// >>> logic/bors_filter.sv
// Sync and dip qualifier for the supply-low input
`timescale 1ns/1ps
module bors_filter (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic low_i,
  output logic low_sync_o,
  output logic low_qual_o
);
  import bors_pkg::*;

  logic [2:0] sync_q;
  logic [2:0] sync_d;
  logic stable_q;
  logic stable_d;
  logic [DIP_W-1:0] cnt_q;
  logic [DIP_W-1:0] cnt_d;
  logic qual_q;
  logic qual_d;

  // Three-stage sync; a change counts once stages two and three agree
  always_comb begin
    sync_d = {sync_q[1:0], low_i};
    stable_d = stable_q;
    if (sync_q[2] == sync_q[1]) begin
      stable_d = sync_q[2];
    end
    cnt_d = cnt_q;
    qual_d = qual_q;
    if (!stable_q) begin
      cnt_d = '0;
      qual_d = 1'b0;
    end else if (cnt_q < DIP_W'(DIP_CYCLES)) begin
      // Short dips never reach the count, so never reset the chip once running
      cnt_d = cnt_q + DIP_W'(1);
    end else begin
      qual_d = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync_q <= 3'h0;
      stable_q <= 1'b0;
      cnt_q <= '0;
      qual_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
      stable_q <= stable_d;
      cnt_q <= cnt_d;
      qual_q <= qual_d;
    end
  end

  assign low_sync_o = stable_q;
  assign low_qual_o = qual_q;
endmodule

// >>> logic/bors_sequencer.sv
// Brown-out reset sequencer with start-up delays and wake handling
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
module bors_sequencer #(
  // Power-up delay in clock cycles; a test may shorten it
  parameter int unsigned PWRUP_CYC = bors_pkg::PWRUP_CYCLES
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic brownout_enable_fuse_i,
  input wire logic supply_low_i,
  input wire logic master_clear_input_n_i,
  input wire logic wdt_timeout_i,
  input wire logic osc_tick_i,
  input wire logic sleeping_i,
  input wire logic global_irq_disable_i,
  input wire logic [bors_pkg::CAUSE_W-1:0] core_irq_cause_i,
  input wire logic [bors_pkg::CAUSE_W-1:0] periph_a_cause_i,
  input wire logic [bors_pkg::CAUSE_W-1:0] periph_b_cause_i,
  output logic chip_reset_n_o,
  output bors_pkg::bors_reset_kind_t reset_kind_o,
  output logic load_defaults_o,
  output logic set_global_irq_disable_o,
  output bors_pkg::bors_pc_t pc_o,
  output bors_pkg::bors_wake_t wake_o
);
  import bors_pkg::*;

  // ----------------------------------------------------------------
  // Input conditioning
  // ----------------------------------------------------------------
  logic low_sync;
  logic low_qual;
  logic [2:0] master_clear_input_sync_q;
  logic [2:0] master_clear_input_sync_d;
  logic master_clear_input_q;
  logic master_clear_input_d;

  bors_filter u_filter (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .low_i(supply_low_i),
    .low_sync_o(low_sync),
    .low_qual_o(low_qual)
  );

  // Master clear pin is asynchronous; same three-stage treatment
  always_comb begin
    master_clear_input_sync_d = {master_clear_input_sync_q[1:0], ~master_clear_input_n_i};
    master_clear_input_d = master_clear_input_q;
    if (master_clear_input_sync_q[2] == master_clear_input_sync_q[1]) begin
      master_clear_input_d = master_clear_input_sync_q[2];
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      master_clear_input_sync_q <= 3'h0;
      master_clear_input_q <= 1'b0;
    end else begin
      master_clear_input_sync_q <= master_clear_input_sync_d;
      master_clear_input_q <= master_clear_input_d;
    end
  end

  // ----------------------------------------------------------------
  // Reset sequencing state machine
  // ----------------------------------------------------------------
  logic bor_active;
  logic bor_trip;
  logic lowsup_hold;
  bors_state_t state_q;
  bors_state_t state_d;
  logic [CNT_W-1:0] powerup_delay_timer_q;
  logic [CNT_W-1:0] powerup_delay_timer_d;
  logic [10:0] ost_q;
  logic [10:0] ost_d;
  logic rst_n_q;
  logic rst_n_d;
  bors_reset_kind_t kind_q;
  bors_reset_kind_t kind_d;
  logic dflt_q;
  logic dflt_d;

  assign bor_active = brownout_enable_fuse_i;
  assign bor_trip = bor_active & low_qual;
  // Once in reset, the raw synced level holds it, no dip filtering
  assign lowsup_hold = bor_active & low_sync;

  always_comb begin
    state_d = state_q;
    powerup_delay_timer_d = powerup_delay_timer_q;
    ost_d = ost_q;
    kind_d = kind_q;
    rst_n_d = rst_n_q;
    dflt_d = 1'b0;
    case (state_q)
      BORS_ST_HOLD: begin
        rst_n_d = 1'b0;
        powerup_delay_timer_d = '0;
        ost_d = '0;
        if (!lowsup_hold && !master_clear_input_q) begin
          state_d = BORS_ST_DELAY;
        end
      end
      BORS_ST_DELAY: begin
        rst_n_d = 1'b0;
        if (lowsup_hold) begin
          state_d = BORS_ST_HOLD;
          kind_d = BORS_RK_LOWSUP;
          dflt_d = 1'b1;
        end else if (master_clear_input_q) begin
          state_d = BORS_ST_HOLD;
          kind_d = BORS_RK_MASTER_CLEAR_INPUT;
          dflt_d = 1'b1;
        end else begin
          // Both timers run; release waits for the later one
          if (powerup_delay_timer_q < CNT_W'(PWRUP_CYC)) begin
            powerup_delay_timer_d = powerup_delay_timer_q + CNT_W'(1);
          end
          if (osc_tick_i && ost_q < 11'(OSC_STARTUP_PERIODS)) begin
            ost_d = ost_q + 11'h001;
          end
          if (powerup_delay_timer_q >= CNT_W'(PWRUP_CYC) &&
              ost_q >= 11'(OSC_STARTUP_PERIODS)) begin
            state_d = BORS_ST_RUN;
            rst_n_d = 1'b1;
          end
        end
      end
      BORS_ST_RUN: begin
        if (bor_trip) begin
          state_d = BORS_ST_HOLD;
          kind_d = BORS_RK_LOWSUP;
          rst_n_d = 1'b0;
          dflt_d = 1'b1;
        end else if (master_clear_input_q) begin
          state_d = BORS_ST_HOLD;
          kind_d = BORS_RK_MASTER_CLEAR_INPUT;
          rst_n_d = 1'b0;
          dflt_d = 1'b1;
        end else if (wdt_timeout_i) begin
          // Watchdog reset also reruns the start-up delays from zero
          state_d = BORS_ST_DELAY;
          powerup_delay_timer_d = '0;
          ost_d = '0;
          kind_d = BORS_RK_WDT;
          rst_n_d = 1'b0;
          dflt_d = 1'b1;
        end
      end
      default: begin
        state_d = BORS_ST_HOLD;
        rst_n_d = 1'b0;
      end
    endcase
  end

  // Power-on is the asynchronous reset; defaults load from it
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= BORS_ST_HOLD;
      powerup_delay_timer_q <= '0;
      ost_q <= 11'h000;
      rst_n_q <= 1'b0;
      kind_q <= BORS_RK_POWERON;
      dflt_q <= 1'b1;
    end else begin
      state_q <= state_d;
      powerup_delay_timer_q <= powerup_delay_timer_d;
      ost_q <= ost_d;
      rst_n_q <= rst_n_d;
      kind_q <= kind_d;
      dflt_q <= dflt_d;
    end
  end

  // ----------------------------------------------------------------
  // Wake from sleep and interrupt vectoring
  // ----------------------------------------------------------------
  logic [CAUSE_W-1:0] any_cause;
  bors_wake_t wake_q;
  bors_wake_t wake_d;
  bors_pc_t pc_q;
  bors_pc_t pc_d;
  logic gdis_q;
  logic gdis_d;

  assign any_cause = core_irq_cause_i | periph_a_cause_i | periph_b_cause_i;

  always_comb begin
    wake_d = '0;
    pc_d = '0;
    gdis_d = 1'b0;
    if (!rst_n_q) begin
      // Reset leaves flags at defaults and the counter at the reset vector
      wake_d.core_cause = CAUSE_RST;
      pc_d.addr = RESET_VECTOR;
    end else if (sleeping_i && |any_cause) begin
      // Cause flags reported; other contents stay untouched
      wake_d.valid = 1'b1;
      wake_d.core_cause = core_irq_cause_i;
      wake_d.periph_a_cause = periph_a_cause_i;
      wake_d.periph_b_cause = periph_b_cause_i;
      if (!global_irq_disable_i) begin
        pc_d.load = 1'b1;
        pc_d.push = 1'b1;
        pc_d.addr = IRQ_VECTOR;
        gdis_d = 1'b1;
      end
    end else if (!sleeping_i && |any_cause && !global_irq_disable_i) begin
      pc_d.load = 1'b1;
      pc_d.push = 1'b1;
      pc_d.addr = IRQ_VECTOR;
      gdis_d = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wake_q <= '0;
      pc_q <= '0;
      gdis_q <= 1'b0;
    end else begin
      wake_q <= wake_d;
      pc_q <= pc_d;
      gdis_q <= gdis_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all registered
  // ----------------------------------------------------------------
  assign chip_reset_n_o = rst_n_q;
  assign reset_kind_o = kind_q;
  assign load_defaults_o = dflt_q;
  assign pc_o = pc_q;
  assign wake_o = wake_q;
  assign set_global_irq_disable_o = gdis_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  fuse_off_run_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (!brownout_enable_fuse_i && state_q == BORS_ST_RUN && !master_clear_input_q &&
     !wdt_timeout_i) |=> state_q == BORS_ST_RUN)
    else $error("reset taken with brown-out fuse clear");
  low_hold_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (lowsup_hold && !chip_reset_n_o) |=> !chip_reset_n_o)
    else $error("reset released while supply low");
  trip_reset_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (bor_trip && state_q == BORS_ST_RUN) |=> !chip_reset_n_o &&
    reset_kind_o == BORS_RK_LOWSUP)
    else $error("qualified low supply did not reset");
  delay_min_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    $rose(chip_reset_n_o) |-> $past(powerup_delay_timer_q) >= CNT_W'(PWRUP_CYC) &&
    $past(ost_q) >= 11'(OSC_STARTUP_PERIODS))
    else $error("released before start-up delays ended");
  timer_clear_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (state_q == BORS_ST_DELAY && lowsup_hold) |=> ##1 powerup_delay_timer_q == '0 &&
    ost_q == 11'h000)
    else $error("start-up timers not reinitialised");
  restart_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (state_q == BORS_ST_HOLD && lowsup_hold) |=>
    state_q == BORS_ST_HOLD && powerup_delay_timer_q == '0)
    else $error("timer ran while supply low");
  wake_vec_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (rst_n_q && sleeping_i && |any_cause && !global_irq_disable_i) |=>
    pc_o.load && pc_o.addr == IRQ_VECTOR && set_global_irq_disable_o)
    else $error("irq wake did not vector");
  wake_flag_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (rst_n_q && sleeping_i && |any_cause) |=> wake_o.valid &&
    |(wake_o.core_cause | wake_o.periph_a_cause |
      wake_o.periph_b_cause))
    else $error("wake without cause flags");
  dflt_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    wake_o.valid |-> !load_defaults_o)
    else $error("wake loaded defaults");
  sync_rel_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    $rose(chip_reset_n_o) |-> state_q == BORS_ST_RUN)
    else $error("release not aligned to state");

  release_c: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
    $rose(chip_reset_n_o));
  lowsup_c: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
    state_q == BORS_ST_DELAY && lowsup_hold);
  wake_c: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
    wake_o.valid && pc_o.load);
endmodule

// >>> bench/bors_supply_model.sv
// Behavioural supply detector, oscillator tick source and clear pin
`timescale 1ns/1ps
module bors_supply_model #(
  parameter int unsigned OSC_DIV = 4
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic drop_i,
  output logic supply_low_o,
  output logic osc_tick_o,
  output logic master_clear_input_n_o
);
  logic [7:0] div_q;

  // ----------------------------------------------------------------
  // Detector and oscillator
  // ----------------------------------------------------------------
  // Detector follows the requested supply level one edge later
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_q <= 8'h00;
      osc_tick_o <= 1'b0;
      supply_low_o <= 1'b0;
    end else begin
      supply_low_o <= drop_i;
      osc_tick_o <= (div_q == 8'(OSC_DIV - 1));
      div_q <= (div_q == 8'(OSC_DIV - 1)) ? 8'h00 : div_q + 8'h01;
    end
  end

  // No button on this board, so clear stays released
  assign master_clear_input_n_o = 1'b1;
endmodule

// >>> bench/brownout_reset_sequencer_bench.sv
// Self-checking bench for the brown-out reset sequencer
`timescale 1ns/1ps
module brownout_reset_sequencer_bench;
  import bors_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic fuse = 1'b1;
  logic drop = 1'b0;
  logic sleeping = 1'b0;
  logic gid = 1'b0;
  logic wdt = 1'b0;
  logic [CAUSE_W-1:0] core_c = 8'h00;
  logic [CAUSE_W-1:0] pa_c = 8'h00;
  logic [CAUSE_W-1:0] pb_c = 8'h00;
  logic supply_low, osc_tick, master_clear_input_n;
  logic chip_rst_n, load_def, set_gid;
  bors_reset_kind_t kind;
  bors_pc_t pc;
  bors_wake_t wake;
  int mismatches = 0;
  int n_compared = 0;
  // Shortened power-up delay keeps the run short; above 1024 ticks
  localparam int unsigned SIM_PWRUP = 6000;

  // 10 MHz clock
  always #50 mclk = ~mclk;

  bors_supply_model #(.OSC_DIV(4)) partner (
    .mclk_i(mclk), .reset_n_i(reset_n), .drop_i(drop),
    .supply_low_o(supply_low), .osc_tick_o(osc_tick),
    .master_clear_input_n_o(master_clear_input_n));

  bors_sequencer #(.PWRUP_CYC(SIM_PWRUP)) dut (
    .mclk_i(mclk), .reset_n_i(reset_n), .brownout_enable_fuse_i(fuse),
    .supply_low_i(supply_low), .master_clear_input_n_i(master_clear_input_n),
    .wdt_timeout_i(wdt), .osc_tick_i(osc_tick), .sleeping_i(sleeping),
    .global_irq_disable_i(gid), .core_irq_cause_i(core_c),
    .periph_a_cause_i(pa_c), .periph_b_cause_i(pb_c),
    .chip_reset_n_o(chip_rst_n), .reset_kind_o(kind),
    .load_defaults_o(load_def), .set_global_irq_disable_o(set_gid),
    .pc_o(pc), .wake_o(wake));

  // ----------------------------------------------------------------
  // Compare and report
  // ----------------------------------------------------------------
  task automatic mism(input string msg);
    mismatches++;
    $display("MISMATCH at %0t: %s", $time, msg);
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string m);
    n_compared++;
    if (got !== exp) mism(m);
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) mism("word value differs");
  endtask
  task automatic chk_kind(input bors_reset_kind_t got,
                          input bors_reset_kind_t exp);
    n_compared++;
    if (got !== exp) mism("reset kind differs");
  endtask
  task automatic end_of_test();
    $display("Counts: %0d compared, %0d mismatches", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Power-up with a dip early in the delay; timers must start afresh
  task automatic t_powerup();
    int n;
    chk_bit(chip_rst_n, 1'b0, "chip not held in reset");
    chk_kind(kind, BORS_RK_POWERON);
    chk_bit(load_def, 1'b1, "defaults not loaded");
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (500) @(posedge mclk);
    drop <= 1'b1;
    repeat (40) @(posedge mclk);
    drop <= 1'b0;
    n = 0;
    // Bounded wait; the full delay is long by nature
    while (chip_rst_n !== 1'b1 && n < SIM_PWRUP + 2000) begin
      @(negedge mclk);
      n++;
    end
    if (chip_rst_n !== 1'b1) begin
      mism("reset never released");
      end_of_test();
    end
    chk_bit(n >= SIM_PWRUP, 1'b1, "released early");
    chk_bit(n <= SIM_PWRUP + 60, 1'b1, "released late");
    $display("Test powerup done after %0d cycles", n);
  endtask

  // Wake from sleep, with and without the global disable set
  task automatic t_wake(input logic dis);
    logic sv, sl, sp, sg, sd;
    logic [15:0] addr;
    logic [3*CAUSE_W-1:0] causes;
    {sv, sl, sp, sg, sd} = 5'h00;
    addr = 16'h0000;
    causes = '0;
    @(posedge mclk);
    sleeping <= 1'b1;
    gid <= dis;
    core_c <= 8'h04;
    pa_c <= 8'h01;
    pb_c <= 8'h02;
    repeat (6) begin
      @(negedge mclk);
      if (wake.valid === 1'b1) begin
        sv = 1'b1;
        causes = {wake.core_cause, wake.periph_a_cause, wake.periph_b_cause};
      end
      if (pc.load === 1'b1) begin
        sl = 1'b1;
        addr = pc.addr;
      end
      if (pc.push === 1'b1) sp = 1'b1;
      if (set_gid === 1'b1) sg = 1'b1;
      if (load_def !== 1'b0 || chip_rst_n !== 1'b1) sd = 1'b1;
    end
    @(posedge mclk);
    sleeping <= 1'b0;
    {core_c, pa_c, pb_c} <= '0;
    chk_bit(sv, 1'b1, "no wake event");
    chk_bit(causes === 24'h040102, 1'b1, "wake cause wrong");
    chk_bit(sl, ~dis, "vector load wrong");
    chk_bit(sp, ~dis, "return push wrong");
    chk_bit(sg, ~dis, "disable set wrong");
    if (!dis) chk_word(addr, IRQ_VECTOR);
    chk_bit(sd, 1'b0, "wake touched registers");
    $display("Test wake done, disable %0b", dis);
  endtask

  // Watchdog pulse while running; start-up delay must rerun in full
  task automatic t_wdt();
    int n;
    n = 0;
    @(posedge mclk);
    wdt <= 1'b1;
    @(posedge mclk);
    wdt <= 1'b0;
    @(negedge mclk);
    chk_bit(chip_rst_n, 1'b0, "watchdog did not reset");
    chk_kind(kind, BORS_RK_WDT);
    chk_bit(load_def, 1'b1, "defaults not loaded");
    while (chip_rst_n !== 1'b1 && n < SIM_PWRUP + 2000) begin
      @(negedge mclk);
      n++;
    end
    if (chip_rst_n !== 1'b1) begin
      mism("reset never released after watchdog");
      end_of_test();
    end
    chk_bit(n >= SIM_PWRUP, 1'b1, "watchdog release early");
    chk_bit(n <= SIM_PWRUP + 10, 1'b1, "watchdog release late");
    $display("Test watchdog done after %0d cycles", n);
  endtask

  // Supply dip of a given length; counts cycles spent in reset
  task automatic t_dip(input logic fuse_v, input int len, input logic rst);
    int n_low;
    logic sd;
    n_low = 0;
    sd = 1'b0;
    @(posedge mclk);
    fuse <= fuse_v;
    drop <= 1'b1;
    repeat (len) begin
      @(negedge mclk);
      if (chip_rst_n === 1'b0) n_low++;
      if (load_def === 1'b1) sd = 1'b1;
    end
    @(posedge mclk);
    drop <= 1'b0;
    repeat (20) begin
      @(negedge mclk);
      if (chip_rst_n === 1'b0) n_low++;
    end
    if (!rst) begin
      chk_bit(n_low == 0, 1'b1, "dip caused reset");
    end else begin
      chk_bit(n_low >= len, 1'b1, "reset not held");
      chk_bit(chip_rst_n, 1'b0, "released too soon");
      chk_kind(kind, BORS_RK_LOWSUP);
      chk_bit(sd, 1'b1, "defaults not loaded");
    end
    $display("Test dip done, length %0d", len);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(negedge mclk);
    t_powerup();
    t_wake(1'b0);
    t_wake(1'b1);
    t_wdt();
    t_dip(1'b1, 5, 1'b0);
    t_dip(1'b0, 200, 1'b0);
    t_dip(1'b1, 200, 1'b1);
    end_of_test();
  end
endmodule
